// ### mdc_top.sv
// Descriptor caches and MMU register flush side effects.
// Assumes an APB master and a miss sequencer on the same clock.
//
// Summary of operation
// - Four section base and four section length words.
// - Length field is segment count minus one; bounds the segment index.
// - Section base gives descriptor table start; low three bits zero.
// - Sixteen-entry associative id cache tagged by 29 base bits.
// - Reset clears every id cache valid bit.
// - Id cache is read-only: usable bit 0, zeros 1-2, tag above.
// - Four current ids, picked by section select, updated on base write.
// - Current id reads give id in low four bits; not writable.
// - Eight-entry direct-mapped segment cache indexed by VA bits 19-17.
// - Writing a section base flushes that section's segment entries.
// - Sixty-four associative page cache entries translate addresses.
// - Multi context: tag uses id and VA29-11; flush uses VA31-11.
// - Single context: tag uses valid and VA31-11 only.
// - Bit 11 dropped for 4K pages, bits 11-12 for 8K pages.
// - Page entry keeps address, R, M, W, cacheable, access, id, used.
// - Reset or flush clears page entry valid and used bits.
// - Fault code changes only on fault load or write to default.
// - Fault address loads from VA register on fault and from the probe address on probes.
// - VA register captures the address of every translation except one in the same cycle as a VA write.
// - VA write flushes matching page and segment; contiguous flushes that segment's pages.
// - Config resets to zero; writing it flushes all three caches.
// - Id flush write, in multi context only, flushes pages of that id and all segments.
// - Page descriptor fields: P0, M1, W4, base 31-11.
//
// Added by the designer: the register addresses and register access over APB.
module mdc_top #(
  parameter int unsigned PG_ENTRIES = 64
) (
  // Clock and reset
  input logic i_clock,
  input logic i_reset_n,
  // APB slave
  input logic i_psel,
  input logic i_penable,
  input logic i_pwrite,
  input logic [11:0] i_paddr,
  input logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Translation requests
  input logic i_xlat_valid,
  input logic i_xlat_virtual,
  input logic i_xlat_probe,
  input logic [31:0] i_xlat_va,
  output logic o_xlat_done,
  output mdc_pkg::mdc_xlat_t o_xlat_result,
  // Miss-processing fills and faults
  input logic i_sd_fill_valid,
  input mdc_pkg::mdc_sd_fill_t i_sd_fill,
  input logic i_pd_fill_valid,
  input mdc_pkg::mdc_pd_fill_t i_pd_fill,
  input logic i_fault_valid,
  input logic [31:0] i_fault_code
);
  import mdc_pkg::*;

  localparam int unsigned PG_IW = $clog2(PG_ENTRIES);

  if (PG_ENTRIES < 2 || PG_ENTRIES > 64 ||
      (PG_ENTRIES & (PG_ENTRIES - 1)) != 0) begin : g_bad_size
    $error("bad PG_ENTRIES");
  end

  function automatic logic [5:0] fn_first(input logic [63:0] v);
    logic [5:0] r;
    r = 6'h0;
    for (int k = 63; k >= 0; k--) begin
      if (v[k]) r = 6'(k);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] sec_base_reg [SEC_COUNT];
  logic [31:0] sec_len_reg [SEC_COUNT];
  logic [3:0] cur_id_reg [SEC_COUNT];
  logic [28:0] id_tag_reg [ID_COUNT];
  logic [15:0] id_valid_reg;
  logic [3:0] id_rr_reg;
  logic [31:0] fault_code_reg;
  logic [31:0] fault_address_reg;
  logic [31:0] va_reg;
  logic [31:0] config_reg;
  logic [31:0] sd_w0_reg [SD_COUNT];
  logic [31:0] sd_w1_reg [SD_COUNT];
  logic [31:0] sd_w0_next [SD_COUNT];
  logic [31:0] sd_w1_next [SD_COUNT];
  logic [31:0] pg_w0_reg [PG_ENTRIES];
  logic [31:0] pg_w1_reg [PG_ENTRIES];
  logic [31:0] pg_w0_next [PG_ENTRIES];
  logic [31:0] pg_w1_next [PG_ENTRIES];
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic xlat_done_reg;
  mdc_xlat_t xlat_res_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic acc_cyc, commit, pg_in_range, any_hit, bad, wr_ok;
  logic hit_base, hit_len, hit_cid, hit_idc, hit_fc, hit_fa, hit_va;
  logic hit_cfg, hit_idf, hit_sd, hit_pg;
  logic [1:0] reg_sec;
  logic [PG_IW-1:0] pg_sel;
  logic [31:0] rd_mux;

  assign acc_cyc = i_psel & i_penable;
  // Access ends where pready is high
  assign commit = acc_cyc & pready_reg;
  assign reg_sec = i_paddr[3:2];
  assign pg_sel = i_paddr[PG_IW+2:3];
  assign pg_in_range = int'(i_paddr[8:3]) < PG_ENTRIES;
  assign hit_base = i_paddr[11:4] == OFF_SEC_BASE[11:4];
  assign hit_len = i_paddr[11:4] == OFF_SEC_LEN[11:4];
  assign hit_cid = i_paddr[11:4] == OFF_CUR_ID[11:4];
  assign hit_idc = i_paddr[11:6] == OFF_ID_CACHE[11:6];
  assign hit_fc = i_paddr[11:2] == OFF_FAULT_CODE[11:2];
  assign hit_fa = i_paddr[11:2] == OFF_FAULT_ADDR[11:2];
  assign hit_va = i_paddr[11:2] == OFF_VA[11:2];
  assign hit_cfg = i_paddr[11:2] == OFF_CONFIG[11:2];
  assign hit_idf = i_paddr[11:2] == OFF_ID_FLUSH[11:2];
  assign hit_sd = i_paddr[11:6] == OFF_SEG_CACHE[11:6];
  assign hit_pg = (i_paddr[11:9] == OFF_PAGE_CACHE[11:9]) & pg_in_range;
  assign any_hit = hit_base | hit_len | hit_cid | hit_idc | hit_fc |
                   hit_fa | hit_va | hit_cfg | hit_idf | hit_sd | hit_pg;
  // Refused accesses
  assign bad = ~any_hit | (i_pwrite & (hit_idc | hit_cid)) |
               (~i_pwrite & hit_idf);
  assign wr_ok = commit & i_pwrite & ~bad;

  logic sb_wr, len_wr, fc_wr, va_wr, cfg_wr, idf_wr, sd_wr, pg_wr;
  assign sb_wr = wr_ok & hit_base;
  assign len_wr = wr_ok & hit_len;
  assign fc_wr = wr_ok & hit_fc;
  assign va_wr = wr_ok & hit_va;
  assign cfg_wr = wr_ok & hit_cfg;
  assign idf_wr = wr_ok & hit_idf;
  assign sd_wr = wr_ok & hit_sd;
  assign pg_wr = wr_ok & hit_pg;

  assign rd_mux =
    hit_base ? sec_base_reg[reg_sec] :
    hit_len ? sec_len_reg[reg_sec] :
    hit_cid ? {28'h0, cur_id_reg[reg_sec]} :
    hit_idc ? {id_tag_reg[i_paddr[5:2]], 2'b00,
               id_valid_reg[i_paddr[5:2]]} :
    hit_fc ? fault_code_reg :
    hit_fa ? fault_address_reg :
    hit_va ? va_reg :
    hit_cfg ? config_reg :
    hit_sd ? (i_paddr[2] ? sd_w1_reg[i_paddr[5:3]] :
              sd_w0_reg[i_paddr[5:3]]) :
    hit_pg ? (i_paddr[2] ? pg_w1_reg[pg_sel] : pg_w0_reg[pg_sel]) :
    WORD_RST;

  // One wait state
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= WORD_RST;
    end else if (acc_cyc & ~pready_reg) begin
      pready_reg <= 1'b1;
      pslverr_reg <= bad;
      prdata_reg <= (bad | i_pwrite) ? WORD_RST : rd_mux;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Mode and id allocation
  // ----------------------------------------------------------------
  logic multi;
  logic [1:0] pgsz;
  logic [20:0] sz_mask, lk_mask;
  assign multi = config_reg[CFG_MULTI];
  assign pgsz = config_reg[CFG_PGSZ_LSB+1:CFG_PGSZ_LSB];
  assign sz_mask = (pgsz == PGSZ_4K) ? PG_MASK_4K :
                   (pgsz == PGSZ_8K) ? PG_MASK_8K : PG_MASK_FULL;
  assign lk_mask = (multi ? PG_MASK_MULTI : PG_MASK_FULL) & sz_mask;

  logic [15:0] id_match;
  logic [5:0] id_match_w, id_free_w;
  logic id_found, id_any_free, id_reuse;
  logic [3:0] new_id;
  for (genvar k = 0; k < ID_COUNT; k++) begin : g_id
    assign id_match[k] = id_valid_reg[k] &
                         (id_tag_reg[k] == i_pwdata[31:3]);
  end
  assign id_match_w = fn_first({48'h0, id_match});
  assign id_free_w = fn_first({48'h0, ~id_valid_reg});
  assign id_found = |id_match;
  assign id_any_free = ~&id_valid_reg;
  assign new_id = id_found ? id_match_w[3:0] :
                  id_any_free ? id_free_w[3:0] : id_rr_reg;
  // Evicted ids drop their pages
  assign id_reuse = sb_wr & ~id_found & ~id_any_free;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      id_valid_reg <= 16'h0000;
      id_rr_reg <= 4'h0;
      for (int s = 0; s < SEC_COUNT; s++) begin
        sec_base_reg[s] <= WORD_RST;
        sec_len_reg[s] <= WORD_RST;
        cur_id_reg[s] <= 4'h0;
      end
      for (int k = 0; k < ID_COUNT; k++) begin
        id_tag_reg[k] <= 29'h0;
      end
    end else begin
      if (cfg_wr) id_valid_reg <= 16'h0000;
      if (sb_wr) begin
        sec_base_reg[reg_sec] <= i_pwdata;
        id_tag_reg[new_id] <= i_pwdata[31:3];
        id_valid_reg[new_id] <= 1'b1;
        cur_id_reg[reg_sec] <= new_id;
      end
      if (id_reuse) id_rr_reg <= id_rr_reg + 4'h1;
      if (len_wr) sec_len_reg[reg_sec] <= i_pwdata;
    end
  end

  // ----------------------------------------------------------------
  // MMU registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      fault_code_reg <= FAULT_CODE_DEFAULT;
      fault_address_reg <= WORD_RST;
      va_reg <= WORD_RST;
      config_reg <= CONFIG_RST;
    end else begin
      if (i_fault_valid) fault_code_reg <= i_fault_code;
      else if (fc_wr) fault_code_reg <= FAULT_CODE_DEFAULT;
      if (i_fault_valid) fault_address_reg <= va_reg;
      else if (i_xlat_valid & i_xlat_probe) fault_address_reg <= i_xlat_va;
      if (va_wr) va_reg <= i_pwdata;
      else if (i_xlat_valid) va_reg <= i_xlat_va;
      if (cfg_wr) config_reg <= i_pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Segment descriptor cache
  // ----------------------------------------------------------------
  logic [2:0] va_sdi, fill_sdi, xl_sdi;
  logic sd_va_match, sd_contig_flush, idf_act;
  assign va_sdi = i_pwdata[VA_SDC_MSB:VA_SEG_LSB];
  assign fill_sdi = i_sd_fill.va[VA_SDC_MSB:VA_SEG_LSB];
  assign xl_sdi = i_xlat_va[VA_SDC_MSB:VA_SEG_LSB];
  assign sd_va_match = sd_w0_reg[va_sdi][SW0_VALID] &
                       (sd_w1_reg[va_sdi][11:0] == i_pwdata[31:20]);
  assign sd_contig_flush = va_wr & sd_va_match &
                           sd_w0_reg[va_sdi][SW0_CONTIG];
  assign idf_act = idf_wr & multi;

  for (genvar j = 0; j < SD_COUNT; j++) begin : g_sd
    logic sd_flush;
    assign sd_flush = cfg_wr | idf_act |
      (sb_wr & (sd_w1_reg[j][11:10] == reg_sec)) |
      (va_wr & (va_sdi == 3'(j)) & sd_va_match);
    always_comb begin
      sd_w0_next[j] = sd_w0_reg[j];
      sd_w1_next[j] = sd_w1_reg[j];
      if (i_sd_fill_valid & (fill_sdi == 3'(j))) begin
        sd_w0_next[j] = {i_sd_fill.word0[31:1], 1'b1};
        sd_w1_next[j] = {i_sd_fill.word1[31:12],
                         i_sd_fill.va[31:VA_SDC_TAG_LSB]};
      end
      if (sd_wr & (i_paddr[5:3] == 3'(j))) begin
        if (i_paddr[2]) sd_w1_next[j] = i_pwdata;
        else sd_w0_next[j] = i_pwdata;
      end
      if (sd_flush) sd_w0_next[j][SW0_VALID] = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    for (int j = 0; j < SD_COUNT; j++) begin
      sd_w0_reg[j] <= i_reset_n ? sd_w0_next[j] : WORD_RST;
      sd_w1_reg[j] <= i_reset_n ? sd_w1_next[j] : WORD_RST;
    end
  end

  // ----------------------------------------------------------------
  // Page descriptor cache
  // ----------------------------------------------------------------
  logic [63:0] lk_hit, pg_free, pg_unused;
  logic [5:0] hit_w, free_w, unused_w, victim_w;
  logic [3:0] xl_id, fl_id, idn_flush_id, fill_id;
  logic fill_ok, used_clr_all, idn_flush_en;
  logic [31:0] fill_w0, fill_w1;

  assign xl_id = cur_id_reg[i_xlat_va[31:VA_SID_LSB]];
  assign fl_id = cur_id_reg[i_pwdata[31:VA_SID_LSB]];
  assign fill_id = multi ? cur_id_reg[i_pd_fill.va[31:VA_SID_LSB]] : 4'h0;
  assign idn_flush_en = (idf_act & id_found) | id_reuse;
  assign idn_flush_id = id_reuse ? new_id : id_match_w[3:0];
  assign fill_ok = i_pd_fill_valid & i_pd_fill.desc[PD_PRESENT];
  assign fill_w0 = {1'b1, 1'b1, fill_id,
                    i_pd_fill.va[31:VA_PAGE_LSB], 2'b00,
                    i_pd_fill.cacheable, i_pd_fill.contig, 1'b0};
  assign fill_w1 = {i_pd_fill.acc, i_pd_fill.desc[PD_REF],
                    i_pd_fill.desc[PD_MOD], i_pd_fill.desc[PD_WFAULT],
                    i_pd_fill.desc[31:VA_PAGE_LSB]};
  assign hit_w = fn_first(lk_hit);
  assign free_w = fn_first(pg_free);
  assign unused_w = fn_first(pg_unused);
  // Invalid slots first, then unused
  assign victim_w = (|pg_free) ? free_w : (|pg_unused) ? unused_w :
                    6'h0;
  assign used_clr_all = fill_ok & ~(|pg_free) & ~(|pg_unused);

  for (genvar i = 0; i < 64; i++) begin : g_pg
    if (i < PG_ENTRIES) begin : g_on
      logic [20:0] ent_va;
      logic [3:0] ent_id;
      logic ent_v, fl_hit, seg_fl, id_fl, pg_flush, fill_sel;
      assign ent_va = pg_w0_reg[i][25:5];
      assign ent_id = pg_w0_reg[i][29:26];
      assign ent_v = pg_w0_reg[i][PW0_VALID];
      assign pg_free[i] = ~ent_v;
      assign pg_unused[i] = ent_v & ~pg_w0_reg[i][PW0_USED];
      assign lk_hit[i] = ent_v &
        (((ent_va ^ i_xlat_va[31:11]) & lk_mask) == 21'h0) &
        (~multi | (ent_id == xl_id));
      assign fl_hit = ent_v &
        (((ent_va ^ i_pwdata[31:11]) & sz_mask) == 21'h0) &
        (~multi | (ent_id == fl_id));
      assign seg_fl = ent_v & (ent_va[20:6] == i_pwdata[31:17]) &
        (~multi | (ent_id == fl_id));
      assign id_fl = ent_v & (ent_id == idn_flush_id);
      assign pg_flush = cfg_wr |
        (va_wr & (fl_hit | (sd_contig_flush & seg_fl))) |
        (idn_flush_en & id_fl);
      assign fill_sel = fill_ok & (victim_w == 6'(i));
      always_comb begin
        pg_w0_next[i] = pg_w0_reg[i];
        pg_w1_next[i] = pg_w1_reg[i];
        if (used_clr_all) pg_w0_next[i][PW0_USED] = 1'b0;
        if (i_xlat_valid & i_xlat_virtual & lk_hit[i]) begin
          pg_w0_next[i][PW0_USED] = 1'b1;
        end
        if (fill_sel) begin
          pg_w0_next[i] = fill_w0;
          pg_w1_next[i] = fill_w1;
        end
        if (pg_wr & (pg_sel == PG_IW'(i))) begin
          if (i_paddr[2]) pg_w1_next[i] = i_pwdata;
          else pg_w0_next[i] = i_pwdata;
        end
        if (pg_flush) begin
          pg_w0_next[i][PW0_VALID] = 1'b0;
          pg_w0_next[i][PW0_USED] = 1'b0;
        end
      end
    end else begin : g_off
      assign lk_hit[i] = 1'b0;
      assign pg_free[i] = 1'b0;
      assign pg_unused[i] = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    for (int i = 0; i < PG_ENTRIES; i++) begin
      pg_w0_reg[i] <= i_reset_n ? pg_w0_next[i] : WORD_RST;
      pg_w1_reg[i] <= i_reset_n ? pg_w1_next[i] : WORD_RST;
    end
  end

  // ----------------------------------------------------------------
  // Translation result
  // ----------------------------------------------------------------
  logic [31:0] hw0, hw1, sbase;
  logic [1:0] xsid;
  logic [12:0] xseg;
  logic [20:0] pa_hi;
  mdc_xlat_t xl_next;
  assign hw0 = pg_w0_reg[hit_w[PG_IW-1:0]];
  assign hw1 = pg_w1_reg[hit_w[PG_IW-1:0]];
  assign xsid = i_xlat_va[31:VA_SID_LSB];
  assign xseg = i_xlat_va[VA_SEG_MSB:VA_SEG_LSB];
  assign sbase = sec_base_reg[xsid];
  // Page bits dropped for the page size come from the VA
  assign pa_hi = (hw1[20:0] & sz_mask) | (i_xlat_va[31:11] & ~sz_mask);

  always_comb begin
    xl_next = '0;
    if (!i_xlat_virtual) begin
      xl_next.hit = 1'b1;
      xl_next.paddr = i_xlat_va;
    end else begin
      xl_next.hit = |lk_hit;
      xl_next.seg_hit = sd_w0_reg[xl_sdi][SW0_VALID] &
        (sd_w1_reg[xl_sdi][11:0] == i_xlat_va[31:VA_SDC_TAG_LSB]);
      xl_next.bound_err = xseg >
        sec_len_reg[xsid][SEC_LEN_MSB:SEC_LEN_LSB];
      xl_next.sd_addr = {sbase[31:3] + 29'(xseg), 3'b000};
      if (|lk_hit) begin
        xl_next.paddr = {pa_hi, i_xlat_va[10:0]};
        xl_next.acc = hw1[31:24];
        xl_next.referenced = hw1[23];
        xl_next.modified = hw1[22];
        xl_next.write_fault = hw1[21];
        xl_next.cacheable = hw0[PW0_CACHE];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      xlat_done_reg <= 1'b0;
      xlat_res_reg <= '0;
    end else begin
      xlat_done_reg <= i_xlat_valid;
      if (i_xlat_valid) xlat_res_reg <= xl_next;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_xlat_done = xlat_done_reg;
  assign o_xlat_result = xlat_res_reg;

endmodule

// ### mdc_pkg.sv
// Shared constants and carrier types of the MMU descriptor caches.
// Assumes one clock and 12-bit APB byte offsets.
package mdc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned SEC_COUNT = 4;
  localparam int unsigned ID_COUNT = 16;
  localparam int unsigned SD_COUNT = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_SEC_BASE = 12'h000;
  localparam logic [11:0] OFF_SEC_LEN = 12'h010;
  localparam logic [11:0] OFF_CUR_ID = 12'h020;
  localparam logic [11:0] OFF_ID_CACHE = 12'h040;
  localparam logic [11:0] OFF_FAULT_CODE = 12'h080;
  localparam logic [11:0] OFF_FAULT_ADDR = 12'h084;
  localparam logic [11:0] OFF_VA = 12'h088;
  localparam logic [11:0] OFF_CONFIG = 12'h08C;
  localparam logic [11:0] OFF_ID_FLUSH = 12'h090;
  localparam logic [11:0] OFF_SEG_CACHE = 12'h100;
  localparam logic [11:0] OFF_PAGE_CACHE = 12'h200;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SEC_LEN_LSB = 10;
  localparam int unsigned SEC_LEN_MSB = 22;
  localparam int unsigned VA_SID_LSB = 30;
  localparam int unsigned VA_SEG_LSB = 17;
  localparam int unsigned VA_SEG_MSB = 29;
  localparam int unsigned VA_SDC_MSB = 19;
  localparam int unsigned VA_SDC_TAG_LSB = 20;
  localparam int unsigned VA_PAGE_LSB = 11;
  localparam int unsigned PD_PRESENT = 0;
  localparam int unsigned PD_MOD = 1;
  localparam int unsigned PD_WFAULT = 4;
  localparam int unsigned PD_REF = 5;
  localparam int unsigned PW0_USED = 31;
  localparam int unsigned PW0_VALID = 30;
  localparam int unsigned PW0_CACHE = 2;
  localparam int unsigned SW0_VALID = 0;
  localparam int unsigned SW0_CONTIG = 1;
  localparam int unsigned SW0_CACHE = 2;
  localparam int unsigned CFG_PGSZ_LSB = 0;
  localparam int unsigned CFG_MULTI = 2;
  localparam logic [1:0] PGSZ_4K = 2'h1;
  localparam logic [1:0] PGSZ_8K = 2'h2;

  // ----------------------------------------------------------------
  // Page tag masks over VA31..VA11 and reset values
  // ----------------------------------------------------------------
  localparam logic [20:0] PG_MASK_FULL = 21'h1F_FFFF;
  localparam logic [20:0] PG_MASK_MULTI = 21'h07_FFFF;
  localparam logic [20:0] PG_MASK_4K = 21'h1F_FFFE;
  localparam logic [20:0] PG_MASK_8K = 21'h1F_FFFC;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] FAULT_CODE_DEFAULT = 32'h0000_0500;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hit;
    logic seg_hit;
    logic bound_err;
    logic [31:0] paddr;
    logic [31:0] sd_addr;
    logic [7:0] acc;
    logic cacheable;
    logic referenced;
    logic modified;
    logic write_fault;
  } mdc_xlat_t;

  typedef struct packed {
    logic [31:0] va;
    logic [31:0] desc;
    logic [7:0] acc;
    logic cacheable;
    logic contig;
  } mdc_pd_fill_t;

  typedef struct packed {
    logic [31:0] va;
    logic [31:0] word0;
    logic [31:0] word1;
  } mdc_sd_fill_t;

endpackage

// ### mdc_top_properties.sv
// Checker bound to the descriptor cache top.
// Assumes a compliant APB master and one-cycle translation pulses.
module mdc_chk (
  // Clock, reset and APB
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Translation
  input wire logic i_xlat_valid,
  input wire logic i_xlat_virtual,
  input wire logic [31:0] i_xlat_va,
  input wire logic o_xlat_done,
  input wire mdc_pkg::mdc_xlat_t o_xlat_result
);
  import mdc_pkg::*;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  wire acc_wr = i_psel && i_penable && o_pready && i_pwrite;
  wire acc_rd = i_psel && i_penable && o_pready && !i_pwrite;
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_answer;
    !o_pready ##1 o_pready;
  endsequence
  wait_state_a: assert property (s_setup |=> s_answer)
    else $error("no wait state");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready too long");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  idc_ro_a: assert property (acc_wr && i_paddr[11:6] == 6'h01
    |-> o_pslverr) else $error("id cache written");
  cur_id_ro_a: assert property (acc_wr && i_paddr[11:4] == 8'h02
    |-> o_pslverr) else $error("current id written");
  flush_wo_a: assert property (acc_rd && i_paddr == OFF_ID_FLUSH
    |-> o_pslverr && o_prdata == 32'h0) else $error("id flush read");
  phys_pass_a: assert property (i_xlat_valid && !i_xlat_virtual
    |=> o_xlat_result.hit && o_xlat_result.paddr == $past(i_xlat_va))
    else $error("physical pass");
  hold_result_a: assert property (!i_xlat_valid |=> $stable(o_xlat_result))
    else $error("result moved");
  done_track_a: assert property (i_reset_n
    |=> o_xlat_done == $past(i_xlat_valid)) else $error("done late");
endmodule
bind mdc_top mdc_chk i_mdc_chk (.*);

// ### mdc_cpu_model.sv
// Host CPU and miss sequencer stand-in.
// Assumes pulses are taken at a rising edge.
module mdc_cpu_model (
  // Clock
  input wire logic i_clock,
  // Requests toward the block
  output logic o_xlat_valid,
  output logic o_xlat_virtual,
  output logic o_xlat_probe,
  output logic [31:0] o_xlat_va,
  output logic o_pd_valid,
  output mdc_pkg::mdc_pd_fill_t o_pd_fill,
  output logic o_fault_valid,
  output logic [31:0] o_fault_code
);
  import mdc_pkg::*;
  initial begin
    {o_xlat_valid, o_xlat_virtual, o_xlat_probe, o_pd_valid} = 4'h0;
    {o_xlat_va, o_fault_code, o_fault_valid} = 65'h0;
    o_pd_fill = '0;
  end
  // Data inverted after use so late capture fails
  task automatic xlat(input logic v, input logic p, input logic [31:0] a);
    @(posedge i_clock);
    {o_xlat_valid, o_xlat_virtual, o_xlat_probe, o_xlat_va} <=
      {1'h1, v, p, a};
    @(posedge i_clock);
    o_xlat_valid <= 1'h0;
    o_xlat_va <= ~a;
  endtask
  task automatic fill(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clock);
    o_pd_valid <= 1'h1;
    o_pd_fill <= '{va: a, desc: d, acc: 8'hA5, cacheable: 1'h1,
      contig: 1'h0};
    @(posedge i_clock);
    o_pd_valid <= 1'h0;
    o_pd_fill.desc <= ~d;
  endtask
  task automatic fault(input logic [31:0] c);
    @(posedge i_clock);
    {o_fault_valid, o_fault_code} <= {1'h1, c};
    @(posedge i_clock);
    {o_fault_valid, o_fault_code} <= {1'h0, ~c};
  endtask
endmodule

// ### mdc_top_tb_top.sv
// Self-checking bench: APB tests and translations via the host model.
// Assumes mdc_pkg offsets.
module mdc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mdc_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] VA = 32'h0040_0123;
  localparam logic [31:0] PD = 32'h1234_5833;
  logic i_clock = 1'h0;
  logic i_reset_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata, xva, fcode;
  logic pready, pslverr, done, xv, xvirt, xprb, pdv, fv, err;
  mdc_pd_fill_t pdf;
  mdc_xlat_t res;
  int mismatches = 0;
  int checked = 0;
  always #20 i_clock = ~i_clock;
  mdc_top i_mdc_top (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_xlat_valid(xv), .i_xlat_virtual(xvirt),
    .i_xlat_probe(xprb), .i_xlat_va(xva), .o_xlat_done(done),
    .o_xlat_result(res), .i_sd_fill_valid(1'h0), .i_sd_fill('0),
    .i_pd_fill_valid(pdv), .i_pd_fill(pdf), .i_fault_valid(fv),
    .i_fault_code(fcode));
  mdc_cpu_model i_mdc_cpu_model (.i_clock(i_clock), .o_xlat_valid(xv),
    .o_xlat_virtual(xvirt), .o_xlat_probe(xprb), .o_xlat_va(xva),
    .o_pd_valid(pdv), .o_pd_fill(pdf), .o_fault_valid(fv),
    .o_fault_code(fcode));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n = 0;
    @(posedge i_clock);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge i_clock);
    penable <= 1'h1;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) mismatches++;
    {rdata, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, e);
    apb(1'h0, a, 32'h0);
    chk(rdata & m, e);
  endtask
  task automatic xl(input logic v, input logic p, input logic [31:0] a);
    i_mdc_cpu_model.xlat(v, p, a);
    @(negedge i_clock);
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_clock);
    i_reset_n <= 1'h1;
    rd(OFF_CONFIG, ALL, CONFIG_RST);
    rd(OFF_FAULT_CODE, ALL, FAULT_CODE_DEFAULT);
    rd(OFF_ID_CACHE + 12'h008, ALL, 32'h0);
    wr(OFF_SEC_BASE, 32'h0000_1000);
    wr(OFF_SEC_BASE + 12'h004, 32'h0000_2000);
    wr(OFF_SEC_BASE + 12'h008, 32'h0000_1000);
    rd(OFF_SEC_BASE, ALL, 32'h0000_1000);
    rd(OFF_ID_CACHE, ALL, 32'h0000_1001);
    rd(OFF_ID_CACHE + 12'h004, ALL, 32'h0000_2001);
    rd(OFF_CUR_ID + 12'h004, 32'hF, 32'h1);
    rd(OFF_CUR_ID + 12'h008, 32'hF, 32'h0);
    wr(OFF_SEC_LEN + 12'h00C, 32'h0000_0C00);
    rd(OFF_SEC_LEN + 12'h00C, ALL, 32'h0000_0C00);
    wr(OFF_ID_CACHE, ALL);
    chk({31'h0, err}, 32'h1);
    wr(OFF_CUR_ID, ALL);
    chk({31'h0, err}, 32'h1);
    rd(12'hFFC, ALL, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(OFF_SEG_CACHE, 32'h1);
    wr(OFF_SEG_CACHE + 12'h004, 32'h0);
    wr(OFF_SEG_CACHE + 12'h008, 32'h1);
    wr(OFF_SEG_CACHE + 12'h00C, 32'h0000_0400);
    wr(OFF_SEC_BASE, 32'h0000_3000);
    rd(OFF_SEG_CACHE, 32'h1, 32'h0);
    rd(OFF_SEG_CACHE + 12'h008, 32'h1, 32'h1);
    xl(1'h0, 1'h1, 32'hC0DE_0004);
    rd(OFF_FAULT_ADDR, ALL, 32'hC0DE_0004);
    xl(1'h0, 1'h0, 32'h8765_4320);
    chk({res.hit, res.paddr}, {1'h1, 32'h8765_4320});
    rd(OFF_VA, ALL, 32'h8765_4320);
    i_mdc_cpu_model.fault(32'h0000_0123);
    rd(OFF_FAULT_CODE, ALL, 32'h0000_0123);
    rd(OFF_FAULT_CODE, ALL, 32'h0000_0123);
    rd(OFF_FAULT_ADDR, ALL, 32'h8765_4320);
    wr(OFF_FAULT_CODE, 32'h0);
    rd(OFF_FAULT_CODE, ALL, FAULT_CODE_DEFAULT);
    i_mdc_cpu_model.fill(VA, PD);
    xl(1'h1, 1'h0, VA);
    chk(res.paddr, {PD[31:11], VA[10:0]});
    chk({res.hit, res.referenced, res.modified, res.write_fault}, 4'hF);
    chk({res.bound_err, res.sd_addr}, 33'h1_0000_3100);
    wr(OFF_VA, VA);
    xl(1'h1, 1'h0, VA);
    chk({31'h0, res.hit}, 32'h0);
    i_mdc_cpu_model.fill(VA, PD);
    wr(OFF_CONFIG, 32'h0000_0001);
    xl(1'h1, 1'h0, VA);
    chk({31'h0, res.hit}, 32'h0);
    rd(OFF_ID_CACHE, 32'h1, 32'h0);
    i_mdc_cpu_model.fill(VA, PD);
    xl(1'h1, 1'h0, VA ^ 32'h0000_0800);
    chk({31'h0, res.hit}, 32'h1);
    xl(1'h1, 1'h0, VA ^ 32'h0000_1000);
    chk({31'h0, res.hit}, 32'h0);
    summarize();
  end
  // Tests take under two hundred cycles
  initial begin
    repeat (3000) @(posedge i_clock);
    mismatches++;
    summarize();
  end
endmodule
